// file: shared/spf_pkg.sv
// Shared constants for the parity-framed serial link and its two ends.
`default_nettype none
package spf_pkg;
  localparam int          CLK_PERIOD_NS = 4;
  localparam logic [7:0]  CMD_WRITE     = 8'h02;
  localparam logic [7:0]  CMD_READ      = 8'h03;
  localparam logic [7:0]  CMD_READ_ALT  = 8'h0B;
  localparam logic [7:0]  DUMMY_BYTE    = 8'h00;
  localparam logic [15:0] CTRL_LO_ADDR  = 16'hFFFE;
  localparam logic [15:0] MEM_SIZE      = 16'h0C00;
  localparam int          MEM_AW        = 12;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int          CB_SOFT_RST   = 0;
  localparam int          CB_RADIO      = 1;
  localparam int          CB_INT_EN     = 2;
  localparam int          CB_INT_HIGH   = 3;
  localparam int          CB_INT_DRIVE  = 4;
  localparam int          CB_FRAMED     = 5;
  localparam logic [2:0]  IDX_CMD       = 3'h0;
  localparam logic [2:0]  IDX_AHI       = 3'h1;
  localparam logic [2:0]  IDX_ALO       = 3'h2;
  localparam logic [2:0]  IDX_D0        = 3'h3;
  localparam logic [2:0]  IDX_D1        = 3'h4;
  localparam logic [2:0]  IDX_PAR       = 3'h5;
  localparam logic [2:0]  IDX_LAST      = 3'h7;
  localparam logic [2:0]  BIT_LAST      = 3'h7;
  localparam int          SCK_HALF_NS   = 32;
  localparam int          SCK_HALF_CYC  = SCK_HALF_NS / CLK_PERIOD_NS;
  localparam int          RESTART_NS    = 40000;
  localparam logic [7:0]  HR_CTRL       = 8'h00;
  localparam logic [7:0]  HR_ADDR       = 8'h04;
  localparam logic [7:0]  HR_WDATA      = 8'h08;
  localparam logic [7:0]  HR_STATUS     = 8'h0C;
  localparam logic [7:0]  HR_RDATA      = 8'h10;
  localparam int          HC_GO         = 0;
  localparam int          HC_READ       = 1;
  localparam int          HC_FRAMED     = 2;
  localparam int          HC_ALT_READ   = 3;
  localparam int          HC_INT_HIGH   = 4;
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00, DS_WRITE = 2'b01, DS_READ = 2'b11, DS_IGNORE = 2'b10
  } spf_dev_state_e;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_LOW = 3'b001, HS_HIGH = 3'b011,
    HS_DONE = 3'b010, HS_WAIT = 3'b110
  } spf_host_state_e;
endpackage
`default_nettype wire

// file: shared/spf_link_if.sv
// Serial link between the host controller and the tag device.
`default_nettype none
interface spf_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic int_o;
  logic int_oe;
  modport device (input sck, cs_n, si, output so, so_oe, int_o, int_oe);
  modport host (output sck, cs_n, si, input so, so_oe, int_o, int_oe);
endinterface
`default_nettype wire

// file: core/spf_device.sv
// Tag device end: serial slave, parity framing, control word, memory.
// Operation
// - Framed transfer: command, two address, two data, parity.
// - Write parity covers address and data bytes.
// - Parity mismatch discards the write.
// - Write command byte excluded from parity.
// - Framed read returns two data bytes plus parity.
// - Read command byte excluded from parity.
// - Parity bit set when ones count odd.
// - Control bit 5 selects framing, resets off.
// - Accept only 0x02, 0x03, 0x0B commands.
// - Sixteen-bit registers are little-endian; msg_len takes mem[0] as its high byte.
// - Soft reset restores defaults, clears memory, reads zero.
// - Host waits restart delay then restores settings.
// - Control bit 1 enables radio, resets off.
// - Radio enable checks message; failure flags error.
// - Host keeps radio off while writing memory.
// - Control bit 2 gates the interrupt pin.
// - Control bit 3 selects interrupt polarity.
// - Control bit 4 drives inactive level or floats.
// - Board supplies pull matching polarity when floating.
//
// Chosen here: the AHB-Lite interface to the registers.
`default_nettype none
module spf_device
  import spf_pkg::*;
(
  input  wire logic   I_CLOCK,
  input  wire logic   I_RST_N,
  spf_link_if.device  LINK,
  input  wire logic   I_INT_PENDING,
  input  wire logic   I_FMT_ERR_CLEAR,
  output var  logic   O_RADIO_ENABLE,
  output var  logic   O_FMT_ERROR,
  output var  logic   O_READY
);
  import spf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0]        sync1_reg, sync2_reg, bit_cnt_reg, idx_reg;
  logic              sck_prev_reg, sck_s, cs_s, si_s, sck_rise, sck_fall;
  spf_dev_state_e    state_reg;
  logic [6:0]        rx_sh_reg;
  logic [7:0]        tx_sh_reg, tx_pend_reg, addr_hi_reg, d0_reg, d1_reg;
  logic [7:0]        par_reg, rx_byte, wr_a_dat, wr_b_dat, rd_data, tx_next;
  logic              byte_done, framed, par_ok, wr_a_en, wr_b_en;
  logic [15:0]       ptr_reg, wr_a_addr, wr_b_addr, msg_len;
  logic [7:0]        mem [0:MEM_SIZE-1];
  logic [MEM_AW-1:0] clr_idx_reg;
  logic [7:1]        ctrl_reg;
  logic [7:0]        ctrl_wdat;
  logic              clr_busy_reg, ctrl_hit, fmt_ok, fmt_err_reg;
  logic              int_o_reg, int_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pins are asynchronous to I_CLOCK, so each passes two flip-flops.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sync1_reg    <= 3'h2;
      sync2_reg    <= 3'h2;
      sck_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {LINK.si, LINK.cs_n, LINK.sck};
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sync2_reg[0];
    end
  end

  assign sck_s    = sync2_reg[0];
  assign cs_s     = ~sync2_reg[1];
  assign si_s     = sync2_reg[2];
  assign sck_rise = cs_s & sck_s & ~sck_prev_reg;
  assign sck_fall = cs_s & ~sck_s & sck_prev_reg;
  assign rx_byte  = {rx_sh_reg, si_s};
  assign byte_done = sck_rise & (bit_cnt_reg == BIT_LAST);
  assign framed   = ctrl_reg[CB_FRAMED];

  ////////////////////////////////////////////////////////////////////////////
  // Register and memory read view; the reserved high control byte reads 0.
  always_comb begin
    rd_data = 8'h00;
    if (ptr_reg < MEM_SIZE) begin
      rd_data = mem[ptr_reg[MEM_AW-1:0]];
    end else if (ptr_reg == CTRL_LO_ADDR) begin
      rd_data = {ctrl_reg, 1'b0};
    end
  end

  // Framed read: data, data, then the running parity, then zeros.
  always_comb begin
    tx_next = rd_data;
    if (framed && idx_reg == IDX_PAR) begin
      tx_next = par_reg;
    end else if (framed && idx_reg > IDX_PAR) begin
      tx_next = 8'h00;
    end
  end

  assign par_ok = (par_reg == rx_byte);

  always_comb begin
    wr_a_en   = 1'b0;
    wr_b_en   = 1'b0;
    wr_a_addr = ptr_reg;
    wr_b_addr = ptr_reg + 16'h0001;
    wr_a_dat  = rx_byte;
    wr_b_dat  = d1_reg;
    if (state_reg == DS_WRITE && byte_done && !clr_busy_reg) begin
      if (!framed) begin
        wr_a_en = (idx_reg >= IDX_D0);
      end else if (idx_reg == IDX_PAR && par_ok) begin
        wr_a_en  = 1'b1;
        wr_b_en  = 1'b1;
        wr_a_dat = d0_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg   <= DS_IDLE;
      bit_cnt_reg <= 3'h0;
      idx_reg     <= IDX_CMD;
      rx_sh_reg   <= 7'h00;
      tx_sh_reg   <= 8'h00;
      tx_pend_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      ptr_reg     <= 16'h0000;
      d0_reg      <= 8'h00;
      d1_reg      <= 8'h00;
      par_reg     <= 8'h00;
    end else if (!cs_s) begin
      state_reg   <= DS_IDLE;
      bit_cnt_reg <= 3'h0;
      idx_reg     <= IDX_CMD;
      tx_sh_reg   <= 8'h00;
      tx_pend_reg <= 8'h00;
      par_reg     <= 8'h00;
    end else if (sck_rise) begin
      rx_sh_reg   <= rx_byte[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done) begin
        if (idx_reg != IDX_LAST) idx_reg <= idx_reg + 3'h1;
        case (idx_reg)
          IDX_CMD: begin
            // The command byte never enters the parity tally.
            if (rx_byte == CMD_WRITE) begin
              state_reg <= DS_WRITE;
            end else if (rx_byte == CMD_READ ||
                         rx_byte == CMD_READ_ALT) begin
              state_reg <= DS_READ;
            end else begin
              state_reg <= DS_IGNORE;
            end
          end
          IDX_AHI: begin
            addr_hi_reg <= rx_byte;
            par_reg     <= rx_byte;
          end
          IDX_ALO: begin
            ptr_reg <= {addr_hi_reg, rx_byte};
            par_reg <= par_reg ^ rx_byte;
          end
          default: begin
            if (state_reg == DS_WRITE) begin
              if (idx_reg == IDX_D0) d0_reg <= rx_byte;
              if (idx_reg == IDX_D1) d1_reg <= rx_byte;
              if (idx_reg <= IDX_D1) par_reg <= par_reg ^ rx_byte;
              if (!framed) ptr_reg <= ptr_reg + 16'h0001;
            end else if (state_reg == DS_READ) begin
              tx_pend_reg <= tx_next;
              if (!(framed && idx_reg >= IDX_D1)) begin
                ptr_reg <= ptr_reg + 16'h0001;
              end
              if (idx_reg == IDX_D0) begin
                par_reg <= par_reg ^ rx_byte ^ rd_data;
              end else if (idx_reg == IDX_D1) begin
                par_reg <= par_reg ^ rd_data;
              end
            end
          end
        endcase
      end
    end else if (sck_fall) begin
      // Output data moves only on a falling clock, never while it is high.
      tx_sh_reg <= (bit_cnt_reg == 3'h0) ? tx_pend_reg
                                         : {tx_sh_reg[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The array has no reset; a soft reset sweeps it, one byte a cycle.
  always_ff @(posedge I_CLOCK) begin
    if (clr_busy_reg) begin
      mem[clr_idx_reg] <= 8'h00;
    end else begin
      if (wr_a_en && wr_a_addr < MEM_SIZE) begin
        mem[wr_a_addr[MEM_AW-1:0]] <= wr_a_dat;
      end
      if (wr_b_en && wr_b_addr < MEM_SIZE) begin
        mem[wr_b_addr[MEM_AW-1:0]] <= wr_b_dat;
      end
    end
  end

  // Only the low byte at the even address holds bits; the odd byte is 0.
  assign ctrl_hit  = (wr_a_en && wr_a_addr == CTRL_LO_ADDR) ||
                     (wr_b_en && wr_b_addr == CTRL_LO_ADDR);
  assign ctrl_wdat = (wr_a_en && wr_a_addr == CTRL_LO_ADDR) ? wr_a_dat
                                                            : wr_b_dat;
  assign msg_len   = {mem[0], mem[1]};
  assign fmt_ok    = (msg_len != 16'h0000) &&
                     (msg_len <= MEM_SIZE - 16'h0002);

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_reg     <= CTRL_RESET[7:1];
      fmt_err_reg  <= 1'b0;
      clr_busy_reg <= 1'b0;
      clr_idx_reg  <= '0;
    end else if (ctrl_hit && ctrl_wdat[CB_SOFT_RST]) begin
      ctrl_reg     <= CTRL_RESET[7:1];
      fmt_err_reg  <= 1'b0;
      clr_busy_reg <= 1'b1;
      clr_idx_reg  <= '0;
    end else begin
      if (clr_busy_reg) begin
        clr_idx_reg <= clr_idx_reg + 1'b1;
        if (clr_idx_reg == MEM_AW'(MEM_SIZE - 16'h0001)) clr_busy_reg <= 1'b0;
      end
      if (ctrl_hit) begin
        ctrl_reg <= ctrl_wdat[7:1];
        if (ctrl_wdat[CB_RADIO] && !ctrl_reg[CB_RADIO] && !fmt_ok) begin
          ctrl_reg[CB_RADIO] <= 1'b0;
        end
      end
      // A new error wins over a clear in the same cycle.
      if (ctrl_hit && ctrl_wdat[CB_RADIO] && !ctrl_reg[CB_RADIO] &&
          !fmt_ok) begin
        fmt_err_reg <= 1'b1;
      end else if (I_FMT_ERR_CLEAR) begin
        fmt_err_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      int_o_reg  <= 1'b0;
      int_oe_reg <= 1'b0;
    end else if (!ctrl_reg[CB_INT_EN]) begin
      int_o_reg  <= 1'b0;
      int_oe_reg <= 1'b0;
    end else if (I_INT_PENDING || fmt_err_reg) begin
      int_o_reg  <= ctrl_reg[CB_INT_HIGH];
      int_oe_reg <= 1'b1;
    end else begin
      int_o_reg  <= ~ctrl_reg[CB_INT_HIGH];
      int_oe_reg <= ctrl_reg[CB_INT_DRIVE];
    end
  end

  assign LINK.so        = tx_sh_reg[7];
  assign LINK.so_oe     = cs_s;
  assign LINK.int_o     = int_o_reg;
  assign LINK.int_oe    = int_oe_reg;
  assign O_RADIO_ENABLE = ctrl_reg[CB_RADIO];
  assign O_FMT_ERROR    = fmt_err_reg;
  assign O_READY        = ~clr_busy_reg;
endmodule
`default_nettype wire

// file: core/spf_host.sv
// Host controller end: AHB-Lite registers driving the serial master.
`default_nettype none
module spf_host
  import spf_pkg::*;
#(
  parameter int RESTART_CYC = RESTART_NS / CLK_PERIOD_NS
)(
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  spf_link_if.host         LINK,
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output var  logic [31:0] O_HRDATA,
  output var  logic        O_HREADYOUT,
  output var  logic        O_HRESP
);
  import spf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  spf_host_state_e state_reg;
  logic [4:0]      ctl_reg;
  logic [15:0]     addr_reg;
  logic [15:0]     wdata_reg;
  logic [15:0]     rdata_reg;
  logic            par_err_reg;
  logic            wr_ph_reg;
  logic [7:0]      wa_reg;
  logic [31:0]     hrdata_reg;
  logic [1:0]      so_sync1_reg;
  logic [1:0]      so_sync2_reg;
  logic [31:0]     cnt_reg;
  logic [5:0]      bits_reg;
  logic [55:0]     tx_reg;
  logic [55:0]     rx_reg;
  logic            sck_reg;
  logic            cs_n_reg;
  logic            rst_sent_reg;
  logic            go;
  logic            busy;
  logic [7:0]      wpar;
  logic [7:0]      rd_par;
  logic [7:0]      cmd;
  logic            int_seen;
  logic [31:0]     rd_mux;
  logic [4:0]      ctl_use;

  assign busy = (state_reg != HS_IDLE);
  assign go   = wr_ph_reg && wa_reg == HR_CTRL && I_HWDATA[HC_GO] && !busy;
  assign wpar = addr_reg[15:8] ^ addr_reg[7:0] ^
                wdata_reg[7:0] ^ wdata_reg[15:8];
  // The frame that GO starts must run on the settings written with it.
  assign ctl_use = go ? {I_HWDATA[4:1], 1'b0} : ctl_reg;
  assign cmd  = !ctl_use[HC_READ] ? CMD_WRITE :
                (ctl_use[HC_ALT_READ] ? CMD_READ_ALT : CMD_READ);
  assign int_seen = so_sync2_reg[1] == ctl_reg[HC_INT_HIGH];

  ////////////////////////////////////////////////////////////////////////////
  // Zero-wait slave: read data is registered during the address phase.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (I_HADDR[7:0])
      HR_CTRL:   rd_mux = {27'h0, ctl_reg[4:1], 1'b0};
      HR_ADDR:   rd_mux = {16'h0, addr_reg};
      HR_WDATA:  rd_mux = {16'h0, wdata_reg};
      HR_STATUS: rd_mux = {29'h0, int_seen, par_err_reg, busy};
      HR_RDATA:  rd_mux = {16'h0, rdata_reg};
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wr_ph_reg  <= 1'b0;
      wa_reg     <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      ctl_reg    <= 5'h00;
      addr_reg   <= 16'h0000;
      wdata_reg  <= 16'h0000;
    end else begin
      wr_ph_reg <= I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;
      wa_reg    <= I_HADDR[7:0];
      if (I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE) begin
        hrdata_reg <= rd_mux;
      end
      if (wr_ph_reg && !busy) begin
        case (wa_reg)
          HR_CTRL:  ctl_reg   <= {I_HWDATA[4:1], 1'b0};
          HR_ADDR:  addr_reg  <= I_HWDATA[15:0];
          HR_WDATA: wdata_reg <= I_HWDATA[15:0];
          default:  ctl_reg   <= ctl_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      so_sync1_reg <= 2'h0;
      so_sync2_reg <= 2'h0;
    end else begin
      so_sync1_reg <= {LINK.int_oe ? LINK.int_o : ~ctl_reg[HC_INT_HIGH],
                       LINK.so};
      so_sync2_reg <= so_sync1_reg;
    end
  end

  // The framed read check covers address, dummy and both data bytes.
  assign rd_par = addr_reg[15:8] ^ addr_reg[7:0] ^ DUMMY_BYTE ^
                  rx_reg[23:16] ^ rx_reg[15:8];

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg    <= HS_IDLE;
      cnt_reg      <= 32'h0;
      bits_reg     <= 6'h00;
      tx_reg       <= 56'h0;
      rx_reg       <= 56'h0;
      sck_reg      <= 1'b0;
      cs_n_reg     <= 1'b1;
      rdata_reg    <= 16'h0000;
      par_err_reg  <= 1'b0;
      rst_sent_reg <= 1'b0;
    end else begin
      case (state_reg)
        HS_IDLE: begin
          if (go) begin
            cs_n_reg  <= 1'b0;
            cnt_reg   <= 32'(SCK_HALF_CYC);
            state_reg <= HS_LOW;
            rst_sent_reg <= !ctl_use[HC_READ] &&
                            addr_reg == CTRL_LO_ADDR &&
                            wdata_reg[CB_SOFT_RST];
            if (ctl_use[HC_READ]) begin
              tx_reg   <= {cmd, addr_reg, DUMMY_BYTE, 24'h0};
              bits_reg <= ctl_use[HC_FRAMED] ? 6'd56 : 6'd48;
            end else begin
              tx_reg   <= {cmd, addr_reg, wdata_reg[7:0],
                           wdata_reg[15:8], wpar, 8'h00};
              bits_reg <= ctl_use[HC_FRAMED] ? 6'd48 : 6'd40;
            end
          end
        end
        HS_LOW: begin
          cnt_reg <= cnt_reg - 32'h1;
          if (cnt_reg == 32'h1) begin
            sck_reg   <= 1'b1;
            rx_reg    <= {rx_reg[54:0], so_sync2_reg[0]};
            cnt_reg   <= 32'(SCK_HALF_CYC);
            state_reg <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          cnt_reg <= cnt_reg - 32'h1;
          if (cnt_reg == 32'h1) begin
            sck_reg   <= 1'b0;
            bits_reg  <= bits_reg - 6'h01;
            tx_reg    <= {tx_reg[54:0], 1'b0};
            cnt_reg   <= 32'(SCK_HALF_CYC);
            state_reg <= (bits_reg == 6'h01) ? HS_DONE : HS_LOW;
          end
        end
        HS_DONE: begin
          cnt_reg <= cnt_reg - 32'h1;
          if (cnt_reg == 32'h1) begin
            cs_n_reg <= 1'b1;
            if (ctl_reg[HC_READ] && ctl_reg[HC_FRAMED]) begin
              rdata_reg   <= {rx_reg[15:8], rx_reg[23:16]};
              par_err_reg <= (rd_par != rx_reg[7:0]);
            end else if (ctl_reg[HC_READ]) begin
              rdata_reg   <= {rx_reg[7:0], rx_reg[15:8]};
              par_err_reg <= 1'b0;
            end
            cnt_reg   <= 32'(RESTART_CYC);
            state_reg <= rst_sent_reg ? HS_WAIT : HS_IDLE;
          end
        end
        HS_WAIT: begin
          // Software must restore settings and memory after this wait.
          cnt_reg <= cnt_reg - 32'h1;
          if (cnt_reg == 32'h1) begin
            state_reg <= HS_IDLE;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  assign LINK.sck    = sck_reg;
  assign LINK.cs_n   = cs_n_reg;
  assign LINK.si     = tx_reg[55];
  assign O_HRDATA    = hrdata_reg;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
endmodule
`default_nettype wire

// file: sim/spf_link_monitor.sv
// Checker watching the serial link between host and device.
`default_nettype none
module spf_link_monitor (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic       sck_q;
  logic [6:0] bits_reg;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  // Rising clock edges per frame; a frame carries only whole bytes.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sck_q    <= 1'b0;
      bits_reg <= 7'h00;
    end else begin
      sck_q <= sck;
      if (cs_n) bits_reg <= 7'h00;
      else if (sck && !sck_q) bits_reg <= bits_reg + 7'h01;
    end
  end
  sequence s_high_half;
    sck[*8] ##1 !sck;
  endsequence
  a_sck_idle: assert property (cs_n |-> !sck)
    else $error("link clock moved outside a frame");
  a_half_period: assert property ($rose(sck) |-> s_high_half)
    else $error("link clock high phase has wrong length");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("select gap too short");
  a_frame_bits: assert property ($rose(cs_n) |->
    bits_reg inside {7'h28, 7'h30, 7'h38})
    else $error("frame is not a whole frame");
  a_si_steady: assert property (sck |-> $stable(si))
    else $error("host data moved while clock high");
  a_so_steady: assert property (so_oe && sck |-> $stable(so))
    else $error("device data moved while clock high");
  a_drive_on: assert property ($fell(cs_n) |-> ##[1:6] so_oe)
    else $error("device did not take its data line");
  a_drive_off: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
    else $error("device kept its data line");
endmodule
`default_nettype wire

// file: sim/spi_parity_framing_and_control_test.sv
// Bench driving both link ends through the host register port.
`default_nettype none
`define CHK(n, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      miscompares++; \
      $display("BAD %s exp %h got %h", n, e, g); \
    end \
  end
module spi_parity_framing_and_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spf_pkg::*;
  logic        clk, rst_n, hsel, hwrite, hready, hresp;
  logic        int_pend, err_clr, radio, fmt_err, ready;
  logic [1:0]  htrans;
  logic [1:0]  pin;
  logic [2:0]  mf;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [10:0] itab [6];
  int          miscompares, check_count, cycles;
  spf_link_if spf_link_if_i ();
  assign pin = {spf_link_if_i.int_oe,
                spf_link_if_i.int_oe & spf_link_if_i.int_o};
  spf_device spf_device_i (.I_CLOCK(clk), .I_RST_N(rst_n),
    .LINK(spf_link_if_i), .I_INT_PENDING(int_pend),
    .I_FMT_ERR_CLEAR(err_clr), .O_RADIO_ENABLE(radio),
    .O_FMT_ERROR(fmt_err), .O_READY(ready));
  // A short restart keeps the run brief while still covering the clear.
  spf_host #(.RESTART_CYC(4000)) spf_host_i (.I_CLOCK(clk),
    .I_RST_N(rst_n), .LINK(spf_link_if_i), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp));
  spf_link_monitor spf_link_monitor_i (.I_CLOCK(clk), .I_RST_N(rst_n),
    .sck(spf_link_if_i.sck), .cs_n(spf_link_if_i.cs_n),
    .si(spf_link_if_i.si), .so(spf_link_if_i.so),
    .so_oe(spf_link_if_i.so_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic frame(input logic rdo, input logic [15:0] a,
                       input logic [15:0] d);
    ahb(1'b1, HR_ADDR, {16'h0000, a});
    ahb(1'b1, HR_WDATA, {16'h0000, d});
    ahb(1'b1, HR_CTRL, {27'h0, mf, rdo, 1'b1});
    ahb(1'b0, HR_STATUS, 32'h0);
    while (rd[0] !== 1'b0) ahb(1'b0, HR_STATUS, 32'h0);
    if (rdo) ahb(1'b0, HR_RDATA, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, hsel, hwrite, int_pend, err_clr} = 5'h00;
    {htrans, haddr, hwdata} = '0;
    {mf, miscompares, check_count, cycles} = '0;
    itab = '{{8'h24, 3'h0}, {8'h24, 3'h6}, {8'h3C, 3'h2},
             {8'h3C, 3'h7}, {8'h34, 3'h3}, {8'h20, 3'h4}};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    frame(1'b1, CTRL_LO_ADDR, 16'h0000);
    `CHK("ctl_reset", 16'h0000, rd[15:0]);
    frame(1'b0, CTRL_LO_ADDR, 16'h0020);
    mf = 3'h1;
    frame(1'b1, CTRL_LO_ADDR, 16'h0000);
    `CHK("ctl_framed", 16'h0020, rd[15:0]);
    ahb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 32'h00000000, rd);
    `CHK("hresp", 1'b0, hresp);
    $display("test control done");
    for (int k = 0; k < 2; k++) begin
      mf[1] = k[0];
      frame(1'b0, 16'h0010, k ? 16'h01FE : 16'hA55A);
      frame(1'b1, 16'h0010, 16'h0000);
      `CHK("mem_rd", k ? 16'h01FE : 16'hA55A, rd[15:0]);
      ahb(1'b0, HR_STATUS, 32'h0);
      `CHK("rd_parity", 1'b0, rd[1]);
    end
    $display("test framing done");
    // The host sends no parity byte unframed, so the framed device drops the write.
    mf = 3'h0;
    frame(1'b0, 16'h0010, 16'h1234);
    mf = 3'h1;
    frame(1'b1, 16'h0010, 16'h0000);
    `CHK("discard", 16'h01FE, rd[15:0]);
    `CHK("no_flag", 1'b0, fmt_err);
    $display("test discard done");
    frame(1'b0, 16'h0000, 16'h0000);
    frame(1'b0, CTRL_LO_ADDR, 16'h0022);
    repeat (8) @(posedge clk);
    `CHK("radio_off", 1'b0, radio);
    `CHK("fmt_err", 1'b1, fmt_err);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    frame(1'b0, 16'h0000, 16'h0400);
    frame(1'b0, CTRL_LO_ADDR, 16'h0022);
    repeat (8) @(posedge clk);
    `CHK("radio_on", 1'b1, radio);
    `CHK("fmt_ok", 1'b0, fmt_err);
    frame(1'b0, CTRL_LO_ADDR, 16'h0020);
    `CHK("radio_dis", 1'b0, radio);
    $display("test radio done");
    foreach (itab[k]) begin
      frame(1'b0, CTRL_LO_ADDR, {8'h00, itab[k][10:3]});
      int_pend <= itab[k][2];
      repeat (8) @(posedge clk);
      `CHK("int_pin", itab[k][1:0], pin);
      ahb(1'b0, HR_STATUS, 32'h0);
      `CHK("int_seen", itab[k][1:0] == 2'h2, rd[2]);
    end
    $display("test interrupt done");
    frame(1'b0, CTRL_LO_ADDR, 16'h0021);
    mf = 3'h0;
    `CHK("ready", 1'b1, ready);
    frame(1'b1, CTRL_LO_ADDR, 16'h0000);
    `CHK("ctl_default", 16'h0000, rd[15:0]);
    frame(1'b1, 16'h0010, 16'h0000);
    `CHK("mem_cleared", 16'h0000, rd[15:0]);
    $display("test soft reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
